// [ascs_defs.vh]
// Behaviour
// [RQ1] each result is a 14-bit word built by successive approximation
// [RQ2] control byte with mode bits 0 then 1 starts a calibration cycle
// [RQ3] clock-source bit of the calibration byte picks the calibration clock
// [RQ4] bit 6 of every control byte selects unipolar or bipolar range
// [RQ5] power-down request input low puts the device into shutdown
// [RQ6] hard reset input low halts everything and restores power-on state
// [RQ7] external clock: strobe rests low, pulses high one serial clock at start
// [RQ8] internal clock: strobe low at conversion start, high when finished
// [RQ9] serial input sampled on every rising serial clock while select is low
// [RQ10] leading zeros ignored; first 1 after select fall or completion is start bit
// [RQ11] serial result output changes only on falling serial clock edges
// [RQ12] serial result output is high-impedance while select is high
// [RQ13] control bytes need select low; interface disabled while select high
// [RQ14] three user outputs follow control byte bits 0 to 2
// [RQ15] user outputs cleared at power-on reset and on hard reset
// [RQ16] user outputs hold and stay driven during any shutdown
// [RQ17] select high then low during acquisition or conversion re-arms start hunt
// [RQ18] start bit before conversion ends aborts it and begins new acquisition
// [RQ19] bit 5 picks oscillator or serial clock for conversion steps
// [RQ20] external clock mode: each approximation step paced by serial clock
// [RQ21] short mode: strobe after 7th falling edge, result msb on 8th
// [RQ22] long mode: strobe after 15th falling edge, result msb on 16th
// [RQ23] mode bits: 00 short, 01 calibrate, 10 power-down, 11 long
// [RQ24] range bit 1 means unipolar, 0 means bipolar
// [RQ25] result msb first, straight binary unipolar, two's complement bipolar
// [RQ26] all three user outputs update together on a new control byte
// [RQ27] seven bits follow the start bit; byte acted on only when complete
`ifndef ASCS_DEFS_VH
`define ASCS_DEFS_VH

// ***************************************************************
// control byte layout
// ***************************************************************
`define ASCS_BIT_RANGE    3
`define ASCS_BIT_CLKSRC   2
`define ASCS_BIT_MODE_HI  1
`define ASCS_BIT_MODE_LO  0
`define ASCS_BYTE_RANGE   6
`define ASCS_BYTE_CLKSRC  5
`define ASCS_BYTE_MODE_HI 4
`define ASCS_BYTE_MODE_LO 3
`define ASCS_PART_OFS     1
`define ASCS_MODE_SHORT   2'h0
`define ASCS_MODE_CAL     2'h1
`define ASCS_MODE_PD      2'h2
`define ASCS_MODE_LONG    2'h3
`define ASCS_SR_START     8'h01

// ***************************************************************
// result and timing
// ***************************************************************
`define ASCS_RES_W        14
`define ASCS_RES_MSB_MASK 14'h2000
`define ASCS_ACQ_SHORT    5'h07
`define ASCS_ACQ_LONG     5'h0F
`define ASCS_SYS_CLK_MHZ  40
`define ASCS_INT_OSC_NS   200
`define ASCS_INT_DIV_CYC  ((`ASCS_INT_OSC_NS * `ASCS_SYS_CLK_MHZ) / 1000)
`define ASCS_CAL_STEPS    8'h40

// ***************************************************************
// synchroniser order {comp, hrst_n, pd_n, din, cs_n, sclk}
// ***************************************************************
`define ASCS_SYNC_W       6
`define ASCS_SYNC_RST     6'h1A
`define ASCS_SYNC_SCLK    0
`define ASCS_SYNC_CS      1
`define ASCS_SYNC_DIN     2
`define ASCS_SYNC_PD      3
`define ASCS_SYNC_HRST    4
`define ASCS_SYNC_COMP    5

// ***************************************************************
// controller states
// ***************************************************************
`define ASCS_S_IDLE       5'h01
`define ASCS_S_CTRL       5'h02
`define ASCS_S_CEXT       5'h04
`define ASCS_S_CINT       5'h08
`define ASCS_S_CAL        5'h10

`endif

// [ascs_host.sv]
`timescale 1ns/10ps
module ascs_host (
   output logic sclk,
   output logic cs_n,
   output logic din,
   input  wire  dout,
   input  wire  strobe
);
   logic [63:0] s_dout;
   logic [63:0] s_strb;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din  = 1'b0;
   end
   // select change; released data line shows its inverse
   task automatic sel(input logic v);
      #3;
      cs_n = v;
      if (v)
         din = ~din;
      #50;
   endtask
   // clock idles low; state after fall k is taken just before fall k+1
   task automatic clocks(input logic [63:0] pat, input int n);
      for (int k = 0; k < n; k++) begin
         din = pat[63-k];
         #100 sclk = 1'b1;
         #100;
         if (k > 0)
            s_dout[k-1] = dout;
         if (k > 0)
            s_strb[k-1] = strobe;
         sclk = 1'b0;
      end
   endtask
endmodule

// [ascs_sar.v]
`timescale 1ns/10ps
`include "ascs_defs.vh"
// ***************************************************************
// successive-approximation engine, one decision per step
// ***************************************************************
module ascs_sar (
   input  wire                   sys_clk,
   input  wire                   clr,
   input  wire                   start,
   input  wire                   abort,
   input  wire                   step,
   input  wire                   comp,
   output reg  [`ASCS_RES_W-1:0] trial,
   output reg                    busy,
   output reg                    done
);
   reg [`ASCS_RES_W-1:0] mask_reg;

   always @(posedge sys_clk) begin
      if (clr) begin
         trial    <= {`ASCS_RES_W{1'b0}};
         mask_reg <= {`ASCS_RES_W{1'b0}};
         busy     <= 1'b0;
         done     <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            trial    <= `ASCS_RES_MSB_MASK;
            mask_reg <= `ASCS_RES_MSB_MASK;
            busy     <= 1'b1;
         end else if (abort) begin
            busy     <= 1'b0;
            mask_reg <= {`ASCS_RES_W{1'b0}};
         end else if (step && busy) begin
            // comparator low means input below trial: drop the bit
            trial    <= (comp ? trial : (trial & ~mask_reg)) | (mask_reg >> 1); // RQ1
            mask_reg <= mask_reg >> 1;
            if (mask_reg[0]) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule

// [ascs_sync.v]
`timescale 1ns/10ps
// ***************************************************************
// two-stage synchroniser for pin inputs
// ***************************************************************
module ascs_sync #(
   parameter W       = 1,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   input  wire         sys_clk,
   input  wire         rst,
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);
   reg [W-1:0] meta_reg;

   always @(posedge sys_clk) begin
      if (rst) begin
         meta_reg <= RST_VAL;
         q        <= RST_VAL;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule

// [ascs_top.v]
`timescale 1ns/10ps
`include "ascs_defs.vh"
module ascs_top (
   input  wire                   sys_clk,
   input  wire                   rst,
   input  wire                   sclk,
   input  wire                   cs_n,
   input  wire                   din,
   input  wire                   power_down_request_n,
   input  wire                   hard_reset_n,
   input  wire                   comp_in,
   output reg                    dout,
   output reg                    dout_oe_n,
   output reg                    conversion_strobe,
   output reg                    strobe_oe_n,
   output reg                    user_out_0,
   output reg                    user_out_1,
   output reg                    user_out_2,
   output wire [`ASCS_RES_W-1:0] dac_trial,
   output wire                   conv_busy,
   output reg                    range_unipolar,
   output reg                    clock_internal,
   output reg                    calibrating,
   output reg                    cal_clock_internal,
   output reg                    shutdown
);
   localparam integer INT_DIV_I = `ASCS_INT_DIV_CYC;
   localparam [7:0]   INT_DIV   = INT_DIV_I[7:0];

   // ***************************************************************
   // input synchronisation and edge detection
   // ***************************************************************
   wire [`ASCS_SYNC_W-1:0] sync_q;
   wire                    sclk_s;
   wire                    cs_s;
   wire                    din_s;
   wire                    pd_n_s;
   wire                    hrst_n_s;
   wire                    comp_s;
   reg                     sclk_prev_reg;
   wire                    clr;
   wire                    rise;
   wire                    fall;

   ascs_sync #(
      .W       (`ASCS_SYNC_W),
      .RST_VAL (`ASCS_SYNC_RST)
   ) u_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .d       ({comp_in, hard_reset_n, power_down_request_n, din, cs_n, sclk}),
      .q       (sync_q)
   );

   assign sclk_s   = sync_q[`ASCS_SYNC_SCLK];
   assign cs_s     = sync_q[`ASCS_SYNC_CS];
   assign din_s    = sync_q[`ASCS_SYNC_DIN];
   assign pd_n_s   = sync_q[`ASCS_SYNC_PD];
   assign hrst_n_s = sync_q[`ASCS_SYNC_HRST];
   assign comp_s   = sync_q[`ASCS_SYNC_COMP];

   assign clr  = rst | ~hrst_n_s;                          // RQ6
   // edges only count while select is low
   assign rise = ~cs_s & sclk_s & ~sclk_prev_reg;          // RQ9 RQ13
   assign fall = ~cs_s & ~sclk_s & sclk_prev_reg;          // RQ13

   // ***************************************************************
   // controller registers
   // ***************************************************************
   reg  [4:0]             state_reg;
   reg  [4:0]             state_next;
   reg  [7:0]             ctrl_sr_reg;
   reg  [4:0]             fall_cnt_reg;
   reg                    ext_run_reg;
   reg  [1:0]             mode_reg;
   reg                    sw_pd_reg;
   reg  [7:0]             cal_cnt_reg;
   reg  [7:0]             div_cnt_reg;
   reg  [`ASCS_RES_W-1:0] out_mask_reg;

   wire st_idle = state_reg[0];
   wire st_ctrl = state_reg[1];
   wire st_cext = state_reg[2];
   wire st_cint = state_reg[3];
   wire st_cal  = state_reg[4];

   // ***************************************************************
   // control byte decode
   // ***************************************************************
   wire [7:0] byte_w;
   wire [1:0] b_mode;
   wire       b_conv;
   wire       byte_done;
   wire       hunt;
   wire       cs_abort;

   assign byte_w    = {ctrl_sr_reg[6:0], din_s};
   assign b_mode    = {byte_w[`ASCS_BYTE_MODE_HI], byte_w[`ASCS_BYTE_MODE_LO]}; // RQ23
   assign b_conv    = (b_mode == `ASCS_MODE_SHORT) || (b_mode == `ASCS_MODE_LONG);
   // start bit sits at bit 6 just before the eighth bit arrives
   assign byte_done = rise & st_ctrl & ctrl_sr_reg[6];                       // RQ27
   // leading zeros fall through; first 1 opens a byte, aborting a conversion
   assign hunt      = rise & din_s & pd_n_s & (st_idle | st_cext | st_cint); // RQ10 RQ18
   assign cs_abort  = cs_s & (st_ctrl | st_cext);                            // RQ17

   // partial byte seen before the eighth bit, for the short-mode strobe
   wire [1:0] p_mode;
   wire       p_ext;
   wire       cur_long;
   wire       cur_ext;
   wire [4:0] acq;
   wire [4:0] fall_inc;
   wire       strobe_go;

   assign p_mode   = {ctrl_sr_reg[`ASCS_BYTE_MODE_HI - `ASCS_PART_OFS],
                      ctrl_sr_reg[`ASCS_BYTE_MODE_LO - `ASCS_PART_OFS]};
   assign p_ext    = ~ctrl_sr_reg[`ASCS_BYTE_CLKSRC - `ASCS_PART_OFS];
   assign cur_long = st_ctrl ? (p_mode == `ASCS_MODE_LONG) : (mode_reg == `ASCS_MODE_LONG);
   assign cur_ext  = st_ctrl ? (p_ext && ((p_mode == `ASCS_MODE_SHORT) ||
                                          (p_mode == `ASCS_MODE_LONG))) : st_cext;
   assign acq      = cur_long ? `ASCS_ACQ_LONG : `ASCS_ACQ_SHORT;      // RQ21 RQ22
   assign fall_inc = fall_cnt_reg + 5'h01;
   assign strobe_go = fall & cur_ext & ~ext_run_reg & (fall_inc == acq); // RQ21 RQ22

   // ***************************************************************
   // conversion clocks and approximation engine
   // ***************************************************************
   wire div_run;
   wire int_tick;
   wire int_go;
   wire sar_step;
   wire sar_done;
   wire cal_tick;

   assign div_run  = st_cint | (st_cal & cal_clock_internal);
   assign int_tick = div_run & (div_cnt_reg == INT_DIV - 8'h01);
   assign int_go   = byte_done & b_conv & byte_w[`ASCS_BYTE_CLKSRC];   // RQ19
   // external steps ride the serial clock, internal ones the oscillator
   assign sar_step = (ext_run_reg & rise) | (st_cint & int_tick);      // RQ19 RQ20
   assign cal_tick = cal_clock_internal ? int_tick : rise;             // RQ3

   ascs_sar u_sar (
      .sys_clk (sys_clk),
      .clr     (clr),
      .start   (strobe_go | int_go),
      .abort   (hunt | cs_abort),                                      // RQ18
      .step    (sar_step),
      .comp    (comp_s),
      .trial   (dac_trial),
      .busy    (conv_busy),
      .done    (sar_done)
   );

   // ***************************************************************
   // next state
   // ***************************************************************
   always @* begin
      state_next = state_reg;
      case (state_reg)
         `ASCS_S_IDLE: begin
            if (hunt)
               state_next = `ASCS_S_CTRL;
         end
         `ASCS_S_CTRL: begin
            if (cs_abort)
               state_next = `ASCS_S_IDLE;                              // RQ17
            else if (byte_done) begin
               if (b_mode == `ASCS_MODE_CAL)
                  state_next = `ASCS_S_CAL;                            // RQ2
               else if (!b_conv)
                  state_next = `ASCS_S_IDLE;
               else if (byte_w[`ASCS_BYTE_CLKSRC])
                  state_next = `ASCS_S_CINT;
               else
                  state_next = `ASCS_S_CEXT;
            end
         end
         `ASCS_S_CEXT: begin
            if (hunt)
               state_next = `ASCS_S_CTRL;                              // RQ18
            else if (cs_abort || sar_done)
               state_next = `ASCS_S_IDLE;                              // RQ10 RQ17
         end
         `ASCS_S_CINT: begin
            if (hunt)
               state_next = `ASCS_S_CTRL;                              // RQ18
            else if (sar_done)
               state_next = `ASCS_S_IDLE;                              // RQ10
         end
         `ASCS_S_CAL: begin
            if (cal_tick && cal_cnt_reg == `ASCS_CAL_STEPS - 8'h01)
               state_next = `ASCS_S_IDLE;                              // RQ10
         end
         default: state_next = `ASCS_S_IDLE;
      endcase
   end

   // ***************************************************************
   // sequencing, serial output and pins
   // ***************************************************************
   always @(posedge sys_clk) begin
      if (clr) begin
         sclk_prev_reg      <= 1'b0;
         state_reg          <= `ASCS_S_IDLE;
         ctrl_sr_reg        <= 8'h00;
         fall_cnt_reg       <= 5'h00;
         ext_run_reg        <= 1'b0;
         mode_reg           <= `ASCS_MODE_SHORT;
         sw_pd_reg          <= 1'b0;
         cal_cnt_reg        <= 8'h00;
         div_cnt_reg        <= 8'h00;
         out_mask_reg       <= {`ASCS_RES_W{1'b0}};
         dout               <= 1'b0;
         dout_oe_n          <= 1'b1;
         conversion_strobe  <= 1'b0;
         strobe_oe_n        <= 1'b1;
         user_out_0         <= 1'b0;                                   // RQ15
         user_out_1         <= 1'b0;                                   // RQ15
         user_out_2         <= 1'b0;                                   // RQ15
         range_unipolar     <= 1'b0;
         clock_internal     <= 1'b0;
         calibrating        <= 1'b0;
         cal_clock_internal <= 1'b0;
         shutdown           <= 1'b0;
      end else begin
         sclk_prev_reg <= sclk_s;
         state_reg     <= state_next;

         // byte shifter: start bit loads a marker, then one bit per rise
         if (hunt)
            ctrl_sr_reg <= `ASCS_SR_START;                             // RQ10
         else if (rise && st_ctrl)
            ctrl_sr_reg <= byte_w;                                     // RQ9 RQ27

         if (hunt)
            fall_cnt_reg <= 5'h00;
         else if (fall && (st_ctrl || st_cext) && !ext_run_reg)
            fall_cnt_reg <= fall_inc;

         if (hunt || cs_abort || sar_done)
            ext_run_reg <= 1'b0;
         else if (strobe_go)
            ext_run_reg <= 1'b1;

         // whole byte accepted at once
         if (byte_done) begin
            user_out_0     <= byte_w[0];                               // RQ14 RQ26
            user_out_1     <= byte_w[1];                               // RQ14 RQ26
            user_out_2     <= byte_w[2];                               // RQ14 RQ26
            range_unipolar <= byte_w[`ASCS_BYTE_RANGE];                // RQ4 RQ24
            mode_reg       <= b_mode;
            sw_pd_reg      <= (b_mode == `ASCS_MODE_PD);               // RQ23
            if (b_conv)
               clock_internal <= byte_w[`ASCS_BYTE_CLKSRC];            // RQ19
            if (b_mode == `ASCS_MODE_CAL)
               cal_clock_internal <= byte_w[`ASCS_BYTE_CLKSRC];        // RQ3
         end

         if (byte_done && b_mode == `ASCS_MODE_CAL) begin
            calibrating <= 1'b1;                                       // RQ2
            cal_cnt_reg <= 8'h00;
         end else if (st_cal && cal_tick) begin
            cal_cnt_reg <= cal_cnt_reg + 8'h01;
            if (cal_cnt_reg == `ASCS_CAL_STEPS - 8'h01)
               calibrating <= 1'b0;
         end

         if (!div_run || int_tick)
            div_cnt_reg <= 8'h00;
         else
            div_cnt_reg <= div_cnt_reg + 8'h01;

         // strobe
         if (strobe_go)
            conversion_strobe <= 1'b1;                                 // RQ7
         else if (int_go)
            conversion_strobe <= 1'b0;                                 // RQ8
         else if (st_cint && sar_done)
            conversion_strobe <= 1'b1;                                 // RQ8
         else if (byte_done && b_conv && !ext_run_reg)
            conversion_strobe <= 1'b0;                                 // RQ7
         else if (fall && ext_run_reg && !clock_internal)
            conversion_strobe <= 1'b0;                                 // RQ7

         // result shifter, msb first, one bit per falling edge
         if (hunt || cs_abort)
            out_mask_reg <= {`ASCS_RES_W{1'b0}};
         else if (strobe_go || (st_cint && sar_done))
            out_mask_reg <= `ASCS_RES_MSB_MASK;                        // RQ21 RQ22
         else if (fall && (out_mask_reg != {`ASCS_RES_W{1'b0}}))
            out_mask_reg <= out_mask_reg >> 1;

         if (fall) begin
            // bipolar flips the msb to give two's complement
            dout <= (|(dac_trial & out_mask_reg)) ^
                    (out_mask_reg[`ASCS_RES_W-1] & ~range_unipolar);   // RQ11 RQ25
         end

         dout_oe_n   <= cs_s;                                          // RQ12
         strobe_oe_n <= cs_s & ~clock_internal;
         // user outputs are untouched here, so they hold through shutdown
         shutdown    <= ~pd_n_s | sw_pd_reg;                           // RQ5 RQ16
      end
   end
endmodule

// [ascs_top_sva.sv]
`timescale 1ns/10ps
`include "ascs_defs.vh"
module ascs_top_sva (
   input wire sys_clk,
   input wire rst,
   input wire sclk,
   input wire cs_n,
   input wire power_down_request_n,
   input wire hard_reset_n,
   input wire dout,
   input wire dout_oe_n,
   input wire conversion_strobe,
   input wire user_out_0,
   input wire user_out_1,
   input wire user_out_2,
   input wire conv_busy,
   input wire clock_internal,
   input wire cal_clock_internal,
   input wire calibrating,
   input wire shutdown
);
   // ***************************************************************
   // helper logic
   // ***************************************************************
   logic [7:0] busy_len;
   wire  [2:0] uo = {user_out_2, user_out_1, user_out_0};
   always @(posedge sys_clk) begin
      if (rst || !conv_busy)
         busy_len <= 8'h00;
      else
         busy_len <= busy_len + 8'h01;
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   // ***************************************************************
   // assertions
   // ***************************************************************
   a_dout_hiz: assert property (cs_n[*4] |-> dout_oe_n)
      else $error("dout driven while select high");
   a_dout_fall: assert property ($changed(dout) |-> !$past(sclk, 2))
      else $error("dout moved away from a serial clock fall");
   a_strobe_ext: assert property ($rose(conversion_strobe) && !clock_internal
      && !cal_clock_internal |-> conversion_strobe[*6] ##[1:4] !conversion_strobe)
      else $error("strobe pulse not one serial clock wide");
   a_strobe_busy: assert property ($fell(conversion_strobe) && hard_reset_n
      |-> ##[0:2] conv_busy)
      else $error("strobe fell without a running conversion");
   a_int_done: assert property ($fell(conv_busy) && clock_internal
      |-> ##[0:2] conversion_strobe)
      else $error("strobe not high after internal conversion");
   a_int_len: assert property ($fell(conv_busy) && clock_internal
      |-> busy_len >= 8'h64 && busy_len <= 8'h82)
      else $error("internal conversion length wrong");
   a_hrst_clear: assert property ((!hard_reset_n)[*5]
      |-> uo == 3'h0 && !conv_busy && !shutdown && !calibrating)
      else $error("hard reset did not clear state");
   a_pd_hold: assert property ((!power_down_request_n && hard_reset_n)[*5]
      |-> $stable(uo))
      else $error("user outputs moved in shutdown");
   cover property ($rose(conversion_strobe));
   cover property ($fell(calibrating));
   cover property ($rose(shutdown));
endmodule
bind ascs_top ascs_top_sva ascs_top_sva_i (.sys_clk(sys_clk), .rst(rst), .sclk(sclk),
   .cs_n(cs_n), .power_down_request_n(power_down_request_n), .hard_reset_n(hard_reset_n),
   .dout(dout), .dout_oe_n(dout_oe_n), .conversion_strobe(conversion_strobe),
   .user_out_0(user_out_0), .user_out_1(user_out_1), .user_out_2(user_out_2),
   .conv_busy(conv_busy), .clock_internal(clock_internal),
   .cal_clock_internal(cal_clock_internal), .calibrating(calibrating), .shutdown(shutdown));

// [ascs_top_test.sv]
`timescale 1ns/10ps
`include "ascs_defs.vh"
module ascs_top_test;
   logic                   sys_clk;
   logic                   rst;
   logic                   power_down_request_n;
   logic                   hard_reset_n;
   logic                   comp_in;
   logic [13:0]            vin;
   int                     n_mismatch = 0;
   int                     n_tests = 0;
   int                     n_cyc = 0;
   wire                    sclk, cs_n, din, dout, dout_oe_n;
   wire                    conversion_strobe, strobe_oe_n, conv_busy;
   wire                    user_out_0, user_out_1, user_out_2;
   wire [`ASCS_RES_W-1:0]  dac_trial;
   wire                    range_unipolar, clock_internal, calibrating;
   wire                    cal_clock_internal, shutdown;
   wire [2:0]              uo = {user_out_2, user_out_1, user_out_0};
   wire                    dout_pin = dout_oe_n ? ~dout : dout;
   wire                    strobe_pin = strobe_oe_n ? ~conversion_strobe : conversion_strobe;
   ascs_top ascs_top_i (.sys_clk(sys_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
      .power_down_request_n(power_down_request_n), .hard_reset_n(hard_reset_n),
      .comp_in(comp_in), .dout(dout), .dout_oe_n(dout_oe_n),
      .conversion_strobe(conversion_strobe), .strobe_oe_n(strobe_oe_n),
      .user_out_0(user_out_0), .user_out_1(user_out_1), .user_out_2(user_out_2),
      .dac_trial(dac_trial), .conv_busy(conv_busy), .range_unipolar(range_unipolar),
      .clock_internal(clock_internal), .calibrating(calibrating),
      .cal_clock_internal(cal_clock_internal), .shutdown(shutdown));
   ascs_host ascs_host_i (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_pin),
      .strobe(strobe_pin));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // ideal comparator on the trial word
   always @(posedge sys_clk) comp_in <= (dac_trial <= vin);
   always @(posedge sys_clk) begin
      n_cyc++;
      if (n_cyc == 20000) begin
         n_mismatch++;
         finish_test;
      end
   end
   // ***************************************************************
   // helpers
   // ***************************************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic chk_w(input logic [13:0] g, input logic [13:0] e);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_b(input logic g, input logic e);
      chk_w({13'h0000, g}, {13'h0000, e});
   endtask
   function automatic logic [13:0] word(input int off);
      logic [13:0] w;
      for (int i = 0; i < 14; i++) w[13-i] = ascs_host_i.s_dout[off+i];
      return w;
   endfunction
   task automatic frame(input logic [63:0] pat, input int n);
      ascs_host_i.sel(1'b0);
      ascs_host_i.clocks(pat, n);
      ascs_host_i.sel(1'b1);
      cyc(8);
   endtask
   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_ext(input logic uni, input logic lng, input logic [2:0] p,
                        input logic [13:0] v, input int z);
      logic [7:0] b;
      int         k;
      b = {1'b1, uni, 1'b0, lng, lng, p};
      k = (lng ? 14 : 6) + z;
      vin <= v;
      frame({b, 56'h0} >> z, (lng ? 32 : 24) + z);
      chk_w({11'h000, uo}, {11'h000, p});
      chk_b(range_unipolar, uni);
      chk_b(ascs_host_i.s_strb[k-1] | ascs_host_i.s_strb[k+1], 1'b0);
      chk_b(ascs_host_i.s_strb[k], 1'b1);
      chk_w(word(k + 1), uni ? v : v ^ `ASCS_RES_MSB_MASK);
      chk_b(dout_oe_n & strobe_oe_n, 1'b1);
   endtask
   task automatic t_abort(input logic [13:0] v);
      vin <= v;
      frame({8'hC1, 56'h0}, 14);
      frame({8'hC6, 56'h0}, 24);
      chk_w({11'h000, uo}, 14'h0006);
      chk_w(word(7), v);
      frame({8'hC1, 4'h0, 8'hC2, 44'h0}, 40);
      chk_w({11'h000, uo}, 14'h0002);
      chk_w(word(19), v);
   endtask
   task automatic t_pd;
      frame({8'hD3, 56'h0}, 10);
      chk_b(shutdown, 1'b1);
      chk_w({11'h000, uo}, 14'h0003);
      power_down_request_n <= 1'b0;
      cyc(8);
      frame({8'hC5, 56'h0}, 24);
      chk_b(shutdown, 1'b1);
      chk_w({11'h000, uo}, 14'h0003);
      power_down_request_n <= 1'b1;
      cyc(8);
   endtask
   task automatic t_cal(input logic isrc);
      ascs_host_i.sel(1'b0);
      ascs_host_i.clocks({1'b1, 1'b0, isrc, 5'h08, 56'h0}, 8);
      cyc(8);
      chk_b(calibrating, 1'b1);
      chk_b(cal_clock_internal, isrc);
      ascs_host_i.sel(1'b0);
      if (isrc)
         cyc(700);
      else
         ascs_host_i.clocks(64'h0, 70);
      frame(64'h0, 0);
      chk_b(calibrating, 1'b0);
   endtask
   task automatic t_hrst;
      ascs_host_i.sel(1'b0);
      ascs_host_i.clocks({8'hC7, 56'h0}, 12);
      cyc(1);
      chk_b(conv_busy, 1'b1);
      hard_reset_n <= 1'b0;
      cyc(8);
      chk_w({11'h000, uo}, 14'h0000);
      chk_b(conv_busy | calibrating | shutdown, 1'b0);
      hard_reset_n <= 1'b1;
      ascs_host_i.sel(1'b1);
      ascs_host_i.clocks({8'hC7, 56'h0}, 8);
      cyc(8);
      chk_w({11'h000, uo}, 14'h0000);
   endtask
   task automatic t_int(input logic [13:0] v);
      int w;
      vin <= v;
      ascs_host_i.sel(1'b0);
      ascs_host_i.clocks({8'hE6, 56'h0}, 8);
      cyc(8);
      chk_b(conversion_strobe, 1'b0);
      w = 0;
      while (conversion_strobe !== 1'b1 && w < 400) begin
         cyc(1);
         w++;
      end
      chk_b(conversion_strobe, 1'b1);
      chk_b(clock_internal, 1'b1);
      frame(64'h0, 16);
      chk_w(word(0), v);
   endtask
   task automatic finish_test;
      $display("mismatches=%0d comparisons=%0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      power_down_request_n = 1'b1;
      hard_reset_n = 1'b1;
      vin = 14'h0000;
      cyc(16);
      rst <= 1'b0;
      cyc(8);
      t_ext(1'b1, 1'b0, 3'h5, 14'h1A5C, 3'h3);
      t_ext(1'b0, 1'b1, 3'h2, 14'h0F0F, 3'h0);
      t_abort(14'h0001);
      t_pd;
      t_cal(1'b0);
      t_cal(1'b1);
      t_hrst;
      t_int(14'h3FFF);
      finish_test;
   end
endmodule
